// >>> plc_map.vh
`ifndef PLC_MAP_VH
`define PLC_MAP_VH

// ----------------------------------------------------------------------
// Clock and blink timing
// ----------------------------------------------------------------------
`define PLC_CLK_KHZ         50000
`define PLC_FAST_BLINK_MS   40
`define PLC_SLOW_BLINK_MS   160
`define PLC_TICK_W          24

// ----------------------------------------------------------------------
// Indicator modes
// ----------------------------------------------------------------------
`define PLC_MODE_W          4
`define PLC_MODE0           4'h0
`define PLC_MODE1           4'h1
`define PLC_MODE2           4'h2
`define PLC_MODE3           4'h3
`define PLC_MODE_TEST_HI    3
`define PLC_MODE_TEST_LO    2

// ----------------------------------------------------------------------
// Strap groups (indicator group number 1..9) and bits
// ----------------------------------------------------------------------
`define PLC_GRP_AN_LO       1
`define PLC_GRP_AN_HI       2
`define PLC_GRP_SPD_LO      3
`define PLC_GRP_SPD_HI      4
`define PLC_GRP_DUP_LO      5
`define PLC_GRP_DUP_HI      9
`define PLC_GRP_MISC        6
`define PLC_BIT_BACKOFF     3
`define PLC_BIT_RETRY       2

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define PLC_ADDR_W          4
`define PLC_ADDR_STRAP      4'h0
`define PLC_ADDR_PORTCFG    4'h4
`define PLC_ADDR_CTRL       4'h8
`define PLC_ADDR_STATUS     4'hc
`define PLC_CTRL_EN         0
`define PLC_CTRL_LAMPTEST   1
`define PLC_CTRL_RST        2'h1
`define PLC_STRAP_TEST      4
`define PLC_STRAP_BACKOFF   5
`define PLC_STRAP_RETRY     6
`define PLC_PCFG_SPD        8
`define PLC_PCFG_DUP        16
`define PLC_STAT_FSD        16

`endif

// >>> plc_tick_gen.v
`timescale 1ns/10ps
module plc_tick_gen #(
    parameter W   = 24,
    parameter CYC = 2000000
) (
    input  wire         clk,
    input  wire         rst,
    output reg          tick_q
);
    reg [W-1:0] cnt_q;

    always @(posedge clk) begin
        if (rst) begin
            cnt_q  <= {W{1'b0}};
            tick_q <= 1'b0;
        end else if (cnt_q == CYC[W-1:0] - 1'b1) begin
            cnt_q  <= {W{1'b0}};
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end
endmodule

// >>> plc_top.v
// Contract
// RULE_01: Indicator pins are inputs during reset and outputs once reset has ended.
// RULE_02: Straps are sampled only at reset; float, pull-down, pull-up are the settings.
// RULE_03: Latch all straps at reset release and hold them until the next reset.
// RULE_04: Mode select 0000..0011 picks indicator modes 0..3, other codes are test.
// RULE_05: Board keeps the upper two mode select bits low for normal use.
// RULE_06: Indicator 0, active low, shows 100 lit and 10 dark in modes 0 and 3.
// RULE_07: Mode 1 indicator 0 shows speed, link, activity; slow blink 10, fast 100.
// RULE_08: Mode 2 indicator 0 is lit while a collision is present.
// RULE_09: Indicator 1 shows full duplex in modes 0 to 2; reserved in mode 3.
// RULE_10: Indicator 2 shows collision in mode 0 and transmit in mode 1.
// RULE_11: Mode 2 indicator 2 shows link activity for a 10Mb port.
// RULE_12: Mode 3 indicator 2: steady for full duplex, intermittent on collision.
// RULE_13: Modes 0 and 3 indicator 3: lit on idle link, dark down, blinks on traffic.
// RULE_14: Indicator 3 shows receive in mode 1 and 100Mb link activity in mode 2.
// RULE_15: Groups 1 and 2 hold auto-negotiation straps; pull-down disables it.
// RULE_16: Groups 3 and 4 hold forced speed; pull-down 10, else 100, only without AN.
// RULE_17: Groups 5 and 9 hold duplex; pull-down full, applied without AN on either end.
// RULE_18: Group 6 bit 3 picks back-off; pull-down less aggressive.
// RULE_19: Group 6 bit 2: pull-down drops after 16 collisions, else retry forever.
// RULE_20: Board ties fiber detect low for copper, drives it from module for fiber.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "plc_map.vh"
module plc_top #(
    parameter NPORT          = 9,
    parameter NSTRAP         = 8,
    parameter FAST_BLINK_CYC = `PLC_FAST_BLINK_MS * `PLC_CLK_KHZ,
    parameter SLOW_BLINK_CYC = `PLC_SLOW_BLINK_MS * `PLC_CLK_KHZ
) (
    input  wire                   clk,
    input  wire                   rst,
    // Shared indicator / strap pins, index (group-1)*4+bit
    input  wire [4*NPORT-1:0]     led_in,
    output reg  [4*NPORT-1:0]     led_out_q,
    output reg  [4*NPORT-1:0]     led_oe_n_q,
    input  wire [3:0]             indicator_mode_select,
    input  wire [NSTRAP-1:0]      fiber_signal_detect,
    // Per-port state from the switch core, same clock
    input  wire [NPORT-1:0]       port_link,
    input  wire [NPORT-1:0]       port_spd100,
    input  wire [NPORT-1:0]       port_full,
    input  wire [NPORT-1:0]       port_col,
    input  wire [NPORT-1:0]       port_tx,
    input  wire [NPORT-1:0]       port_rx,
    input  wire [NSTRAP-1:0]      partner_an,
    // Latched configuration towards the core
    output reg  [1:0]             ind_mode_q,
    output reg                    ind_test_q,
    output reg  [NSTRAP-1:0]      cfg_an_en_q,
    output reg  [NSTRAP-1:0]      cfg_force_spd_q,
    output reg  [NSTRAP-1:0]      cfg_spd100_q,
    output reg  [NSTRAP-1:0]      cfg_force_dup_q,
    output reg  [NSTRAP-1:0]      cfg_full_q,
    output reg                    cfg_backoff_aggr_q,
    output reg                    cfg_retry_forever_q,
    output reg                    cfg_valid_q,
    // Avalon-MM slave
    input  wire [`PLC_ADDR_W-1:0] avs_address,
    input  wire                   avs_read,
    input  wire                   avs_write,
    input  wire [31:0]            avs_writedata,
    input  wire [3:0]             avs_byteenable,
    output reg  [31:0]            avs_readdata,
    output reg                    avs_waitrequest
);
    localparam NPIN = 4 * NPORT;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function integer pin_idx;
        input integer grp;
        input integer bitn;
        begin
            pin_idx = (grp - 1) * 4 + bitn;
        end
    endfunction

    // Port 0..3 sit on the low group bits 3..0, ports 4..7 on the high group
    function integer strap_pin;
        input integer grp_lo;
        input integer grp_hi;
        input integer port;
        begin
            if (port < 4) begin
                strap_pin = pin_idx(grp_lo, 3 - port);
            end else begin
                strap_pin = pin_idx(grp_hi, 7 - port);
            end
        end
    endfunction

    // Lamp "on" pattern for one port, bit n is indicator n
    function [3:0] lamp_on;
        input [1:0] mode;
        input       lnk;
        input       s100;
        input       fdx;
        input       col;
        input       tx;
        input       rx;
        input       phf;
        input       phs;
        reg         act;
        begin
            act = tx | rx;
            case (mode)
                2'd0: begin
                    lamp_on = {lnk & ~(act & phf), col, fdx, s100};
                end
                2'd1: begin
                    lamp_on = {rx, tx, fdx, lnk & ~(act & (s100 ? phf : phs))};
                end
                2'd2: begin
                    lamp_on = {lnk & s100 & ~(act & phf), lnk & ~s100 & ~(act & phs),
                               fdx, col};
                end
                2'd3: begin
                    lamp_on = {lnk & ~(act & phf), fdx | (col & phf), 1'b0, s100};
                end
                default: begin
                    lamp_on = 4'h0;
                end
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg [NPIN-1:0]   pin_s1_q;
    reg [NPIN-1:0]   pin_s2_q;
    reg [3:0]        msel_s1_q;
    reg [3:0]        msel_s2_q;
    reg [NSTRAP-1:0] fsd_s1_q;
    reg [NSTRAP-1:0] fsd_s2_q;
    reg              rst_seen_q;

    always @(posedge clk) begin
        pin_s1_q  <= led_in;
        pin_s2_q  <= pin_s1_q;
        msel_s1_q <= indicator_mode_select;
        msel_s2_q <= msel_s1_q;
        fsd_s1_q  <= fiber_signal_detect;   // [RULE_20]
        fsd_s2_q  <= fsd_s1_q;
        rst_seen_q <= rst;
    end

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    // The two-stage pipeline still holds pin levels from the reset period
    // on the first edge after release, so drivers may switch on then.
    wire capture = rst_seen_q & ~rst;   // [RULE_02]
    reg  [3:0] msel_q;
    reg  [NSTRAP-1:0] an_d;
    reg  [NSTRAP-1:0] spd_d;
    reg  [NSTRAP-1:0] full_d;
    integer k;

    always @* begin
        an_d   = {NSTRAP{1'b0}};
        spd_d  = {NSTRAP{1'b0}};
        full_d = {NSTRAP{1'b0}};
        for (k = 0; k < NSTRAP; k = k + 1) begin
            an_d[k]   = pin_s2_q[strap_pin(`PLC_GRP_AN_LO, `PLC_GRP_AN_HI, k)];   // [RULE_15]
            spd_d[k]  = pin_s2_q[strap_pin(`PLC_GRP_SPD_LO, `PLC_GRP_SPD_HI, k)]; // [RULE_16]
            full_d[k] = ~pin_s2_q[strap_pin(`PLC_GRP_DUP_LO, `PLC_GRP_DUP_HI, k)]; // [RULE_17]
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            led_oe_n_q          <= {NPIN{1'b1}};      // [RULE_01]
            msel_q              <= `PLC_MODE0;
            ind_mode_q          <= 2'd0;
            ind_test_q          <= 1'b0;
            cfg_an_en_q         <= {NSTRAP{1'b1}};
            cfg_spd100_q        <= {NSTRAP{1'b1}};
            cfg_full_q          <= {NSTRAP{1'b0}};
            cfg_backoff_aggr_q  <= 1'b1;
            cfg_retry_forever_q <= 1'b1;
            cfg_valid_q         <= 1'b0;
        end else if (capture) begin
            // Held until the next reset; nothing else loads these
            led_oe_n_q          <= {NPIN{1'b0}};      // [RULE_01] [RULE_03]
            msel_q              <= msel_s2_q;
            ind_mode_q          <= msel_s2_q[1:0];   // [RULE_04]
            ind_test_q          <= |msel_s2_q[`PLC_MODE_TEST_HI:`PLC_MODE_TEST_LO]; // [RULE_04]
            cfg_an_en_q         <= an_d;
            cfg_spd100_q        <= spd_d;
            cfg_full_q          <= full_d;
            cfg_backoff_aggr_q  <= pin_s2_q[pin_idx(`PLC_GRP_MISC, `PLC_BIT_BACKOFF)]; // [RULE_18]
            cfg_retry_forever_q <= pin_s2_q[pin_idx(`PLC_GRP_MISC, `PLC_BIT_RETRY)];   // [RULE_19]
            cfg_valid_q         <= 1'b1;              // [RULE_03]
        end
    end

    // Forced speed only without local AN; duplex also when partner lacks AN
    always @(posedge clk) begin
        if (rst) begin
            cfg_force_spd_q <= {NSTRAP{1'b0}};
            cfg_force_dup_q <= {NSTRAP{1'b0}};
        end else begin
            cfg_force_spd_q <= cfg_valid_q ? ~cfg_an_en_q : {NSTRAP{1'b0}};   // [RULE_16]
            cfg_force_dup_q <= cfg_valid_q ? (~cfg_an_en_q | ~partner_an)
                                           : {NSTRAP{1'b0}};               // [RULE_17]
        end
    end

    // ------------------------------------------------------------------
    // Blink timing
    // ------------------------------------------------------------------
    wire fast_tick;
    wire slow_tick;

    plc_tick_gen #(
        .W   (`PLC_TICK_W),
        .CYC (FAST_BLINK_CYC)
    ) u_fast (
        .clk    (clk),
        .rst    (rst),
        .tick_q (fast_tick)
    );

    plc_tick_gen #(
        .W   (`PLC_TICK_W),
        .CYC (SLOW_BLINK_CYC)
    ) u_slow (
        .clk    (clk),
        .rst    (rst),
        .tick_q (slow_tick)
    );

    // Phase toggles on each tick that saw traffic and clears on a tick without,
    // so the blink keeps the tick period and stops in the lit phase.
    reg [NPORT-1:0] pend_f_q;
    reg [NPORT-1:0] pend_s_q;
    reg [NPORT-1:0] ph_f_q;
    reg [NPORT-1:0] ph_s_q;
    wire [NPORT-1:0] act = port_tx | port_rx;

    always @(posedge clk) begin
        if (rst) begin
            pend_f_q <= {NPORT{1'b0}};
            pend_s_q <= {NPORT{1'b0}};
            ph_f_q   <= {NPORT{1'b0}};
            ph_s_q   <= {NPORT{1'b0}};
        end else begin
            if (fast_tick) begin
                ph_f_q   <= (ph_f_q ^ pend_f_q) & pend_f_q;   // [RULE_07] [RULE_13]
                pend_f_q <= act;
            end else begin
                pend_f_q <= pend_f_q | act;
            end
            if (slow_tick) begin
                ph_s_q   <= (ph_s_q ^ pend_s_q) & pend_s_q;   // [RULE_07] [RULE_11]
                pend_s_q <= act;
            end else begin
                pend_s_q <= pend_s_q | act;
            end
        end
    end

    // ------------------------------------------------------------------
    // Indicator drive (active low)
    // ------------------------------------------------------------------
    reg [1:0] ctrl_q;
    reg [NPIN-1:0] lamp_d;
    integer p;

    always @* begin
        lamp_d = {NPIN{1'b0}};
        for (p = 0; p < NPORT; p = p + 1) begin
            lamp_d[4*p +: 4] = lamp_on(ind_mode_q, port_link[p], port_spd100[p],
                                       port_full[p], port_col[p], port_tx[p],
                                       port_rx[p], ph_f_q[p], ph_s_q[p]);
            // [RULE_06] [RULE_08] [RULE_09] [RULE_10] [RULE_12] [RULE_14]
        end
        if (ind_test_q | ~ctrl_q[`PLC_CTRL_EN]) begin
            lamp_d = {NPIN{1'b0}};
        end
        if (ctrl_q[`PLC_CTRL_LAMPTEST] & ~ind_test_q) begin
            lamp_d = {NPIN{1'b1}};
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            led_out_q <= {NPIN{1'b1}};
        end else begin
            led_out_q <= cfg_valid_q ? ~lamp_d : {NPIN{1'b1}};   // [RULE_06]
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM slave: one wait state on every access
    // ------------------------------------------------------------------
    wire req = avs_read | avs_write;
    reg [31:0] rd_d;

    always @* begin
        rd_d = 32'h0;
        case (avs_address)
            `PLC_ADDR_STRAP: begin
                rd_d[3:0]                = msel_q;
                rd_d[`PLC_STRAP_TEST]    = ind_test_q;
                rd_d[`PLC_STRAP_BACKOFF] = cfg_backoff_aggr_q;
                rd_d[`PLC_STRAP_RETRY]   = cfg_retry_forever_q;
            end
            `PLC_ADDR_PORTCFG: begin
                rd_d[NSTRAP-1:0]                         = cfg_an_en_q;
                rd_d[`PLC_PCFG_SPD +: NSTRAP]            = cfg_spd100_q;
                rd_d[`PLC_PCFG_DUP +: NSTRAP]            = cfg_full_q;
            end
            `PLC_ADDR_CTRL: begin
                rd_d[1:0] = ctrl_q;
            end
            `PLC_ADDR_STATUS: begin
                rd_d[NPORT-1:0]               = port_link;
                rd_d[`PLC_STAT_FSD +: NSTRAP] = fsd_s2_q;   // [RULE_20]
            end
            default: begin
                rd_d = 32'h0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
            ctrl_q          <= `PLC_CTRL_RST;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                avs_readdata <= rd_d;
            end
            if (avs_write & ~avs_waitrequest & avs_byteenable[0] &&
                avs_address == `PLC_ADDR_CTRL) begin
                ctrl_q <= avs_writedata[1:0];
            end
        end
    end
endmodule

// >>> plc_top_monitor.sv
`timescale 1ns/10ps
`include "plc_map.vh"
module plc_top_monitor (
    input wire        clk,
    input wire        rst,
    input wire [35:0] led_out_q,
    input wire [35:0] led_oe_n_q,
    input wire [8:0]  port_link,
    input wire [8:0]  port_spd100,
    input wire [8:0]  port_full,
    input wire [8:0]  port_col,
    input wire [8:0]  port_tx,
    input wire [8:0]  port_rx,
    input wire [7:0]  partner_an,
    input wire [1:0]  ind_mode_q,
    input wire        ind_test_q,
    input wire [7:0]  cfg_an_en_q,
    input wire [7:0]  cfg_force_dup_q,
    input wire        cfg_valid_q,
    input wire [3:0]  avs_address,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire        avs_waitrequest
);
    // ------
    // Indicator checks
    // ------
    wire [8:0] l0, l1, l2, l3;
    reg  [1:0] ctrl_q;
    wire [1:0] m = ind_mode_q;
    wire       wr_ctrl = avs_write && !avs_waitrequest && avs_address == `PLC_ADDR_CTRL;
    // Disable and lamp test override the modes, so mirror the control bits
    wire       norm = cfg_valid_q && !ind_test_q && ctrl_q == 2'h1;
    for (genvar p = 0; p < 9; p++) begin : g_led
        assign {l3[p], l2[p], l1[p], l0[p]} = led_out_q[4*p+:4];
    end
    always @(posedge clk) begin
        if (rst)
            ctrl_q <= 2'h1;
        else if (wr_ctrl && avs_byteenable[0])
            ctrl_q <= avs_writedata[1:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_RST_IDLE: assert property (disable iff (1'b0) rst |=> &led_oe_n_q && &led_out_q)
        else $error("pins not idle in reset");
    AST_DRIVE: assert property (!rst |=> led_oe_n_q == '0 && cfg_valid_q)
        else $error("pins not driven after reset");
    AST_HOLD: assert property (cfg_valid_q |=> $stable({m, ind_test_q, cfg_an_en_q}))
        else $error("latched straps changed");
    AST_FORCE_DUP: assert property ($past(cfg_valid_q) |-> cfg_force_dup_q == $past(~cfg_an_en_q | ~partner_an))
        else $error("forced duplex gate wrong");
    AST_TEST_DARK: assert property ($past(cfg_valid_q && ind_test_q) |-> &led_out_q)
        else $error("test mode lamps lit");
    AST_I0: assert property ($past(norm && m != 2'h1) |-> l0 == ~$past(m[1] ^ m[0] ? port_col : port_spd100))
        else $error("indicator 0 wrong");
    AST_I1: assert property ($past(norm) |-> l1 == ~$past(&m ? 9'h0 : port_full))
        else $error("indicator 1 wrong");
    AST_I2: assert property ($past(norm && !m[1]) |-> l2 == ~$past(m[0] ? port_tx : port_col))
        else $error("indicator 2 wrong");
    AST_I2_M3: assert property ($past(norm && &m) |-> !(l2 & $past(port_full)) && &(l2 | $past(port_full | port_col)))
        else $error("indicator 2 mode 3 wrong");
    AST_I3_RX: assert property ($past(norm && m == 2'h1) |-> l3 == ~$past(port_rx))
        else $error("indicator 3 receive wrong");
    AST_I3_LINK: assert property ($past(norm && m[0] == m[1]) |-> &(l3 | $past(port_link)))
        else $error("indicator 3 lit without link");
    cover property (cfg_valid_q && ind_test_q);
    cover property ($past(norm) && m == 2'h3 && l2 != 9'h1ff);
    cover property (wr_ctrl && avs_writedata[1]);
endmodule

// >>> plc_board.sv
`timescale 1ns/10ps
module plc_board (
    input  wire [35:0] strap,
    input  wire [35:0] led_out_q,
    input  wire [35:0] led_oe_n_q,
    input  wire [3:0]  req_mode,
    input  wire        test_en,
    input  wire [7:0]  fiber_port,
    input  wire [7:0]  module_sd,
    output wire [35:0] led_in,
    output wire [3:0]  indicator_mode_select,
    output wire [7:0]  fiber_signal_detect
);
    // Released pin shows its resistor: 0 pull-down, 1 float or pull-up
    assign led_in = (led_oe_n_q & strap) | (~led_oe_n_q & led_out_q);
    // Upper select bits stay grounded unless a factory mode is wanted
    assign indicator_mode_select = {req_mode[3:2] & {2{test_en}}, req_mode[1:0]};
    assign fiber_signal_detect = fiber_port & module_sd;
endmodule

// >>> testbench.sv
`timescale 1ns/10ps
`include "plc_map.vh"
module testbench;
    logic        clk = 0, rst = 1, test_en = 0, avs_read = 0, avs_write = 0;
    logic [35:0] strap = '1;
    logic [3:0]  req_mode = 0, avs_address = 0, avs_byteenable = 0;
    logic [7:0]  fiber_port = 8'h0f, module_sd = 8'h35, partner_an = 0;
    logic [8:0]  port_link = 0, port_spd100 = 0, port_full = 0;
    logic [8:0]  port_col = 0, port_tx = 0, port_rx = 0;
    logic [31:0] avs_writedata = 0;
    wire  [35:0] led_in, led_out_q, led_oe_n_q;
    wire  [3:0]  indicator_mode_select;
    wire  [7:0]  fiber_signal_detect, cfg_an_en_q, cfg_force_spd_q, cfg_spd100_q;
    wire  [7:0]  cfg_force_dup_q, cfg_full_q;
    wire  [1:0]  ind_mode_q;
    wire         ind_test_q, cfg_backoff_aggr_q, cfg_retry_forever_q, cfg_valid_q;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest;
    int          mismatches = 0, total_checks = 0, cycles = 0;
    plc_top #(.FAST_BLINK_CYC(4), .SLOW_BLINK_CYC(16)) dut (.*);
    plc_board board (.*);
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    // ------
    // Shared tasks
    // ------
    task automatic conclude();
        if (mismatches == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    function automatic logic [8:0] ind(input int n);
        for (int p = 0; p < 9; p++)
            ind[p] = led_out_q[4*p+n];
    endfunction
    function automatic int px(input int lo, input int hi, input int k);
        return ((k < 4 ? lo : hi) - 1) * 4 + 3 - k % 4;
    endfunction
    task automatic toggles(input int pin, output int c);
        logic a;
        c = 0;
        a = led_out_q[pin];
        repeat (96) begin
            @(posedge clk);
            c += led_out_q[pin] !== a;
            a = led_out_q[pin];
        end
    endtask
    task automatic boot(input logic [35:0] s, input logic [3:0] m);
        @(posedge clk);
        rst <= 1;
        strap <= s;
        req_mode <= m;
        test_en <= |m[3:2];
        repeat (20) @(posedge clk);
        chk("oe_reset", '1, led_oe_n_q);
        rst <= 0;
        repeat (3) @(posedge clk);
        chk("oe_run", 0, led_oe_n_q);
    endtask
    task automatic cfg_check(input logic [35:0] s, input logic [3:0] m);
        logic [7:0]  an, sp, fd;
        logic [31:0] q;
        for (int k = 0; k < 8; k++) begin
            an[k] = s[px(1, 2, k)];
            sp[k] = s[px(3, 4, k)];
            fd[k] = !s[px(5, 9, k)];
        end
        chk("an_en", an, cfg_an_en_q);
        chk("spd100", sp, cfg_spd100_q);
        chk("force_spd", 8'(~an), cfg_force_spd_q);
        chk("full", fd, cfg_full_q);
        chk("mode", {|m[3:2], m[1:0]}, {ind_test_q, ind_mode_q});
        bus(0, `PLC_ADDR_STRAP, 0, 4'hf, q);
        chk("strap_reg", {s[22], s[23], |m[3:2], m}, q);
        bus(0, `PLC_ADDR_PORTCFG, 0, 4'hf, q);
        chk("portcfg_reg", {fd, sp, an}, q);
        partner_an <= 8'h3c;
        strap <= ~s;
        req_mode <= ~m;
        repeat (4) @(posedge clk);
        chk("force_dup", 8'(~an | 8'hc3), cfg_force_dup_q);
        chk("hold", {m[1:0], sp, an, s[23:22]}, {ind_mode_q, cfg_spd100_q, cfg_an_en_q,
            cfg_backoff_aggr_q, cfg_retry_forever_q});
    endtask
    // ------
    // Scenarios
    // ------
    task automatic lamps(input logic [1:0] m);
        logic [8:0] e [4];
        port_link <= 9'h1b6;
        port_spd100 <= 9'h0f3;
        port_full <= 9'h155;
        port_col <= m == 3 ? 9'h0 : 9'h0aa;
        port_tx <= 0;
        port_rx <= 0;
        repeat (40) @(posedge clk);
        case (m)
            0: e = '{~port_spd100, ~port_full, ~port_col, ~port_link};
            1: e = '{~port_link, ~port_full, 9'h1ff, 9'h1ff};
            2: e = '{~port_col, ~port_full, ~(port_link & ~port_spd100), ~(port_link & port_spd100)};
            default: e = '{~port_spd100, 9'h1ff, ~port_full, ~port_link};
        endcase
        for (int n = 0; n < 4; n++)
            chk("indicator", e[n], ind(n));
    endtask
    task automatic traffic(input logic [1:0] m);
        int f, s;
        port_link <= 9'h1ff;
        port_spd100 <= 9'h0f5;
        port_tx <= m == 1 ? 9'h0cc : 9'h0;
        port_rx <= m == 1 ? 9'h133 : 9'h1;
        port_col <= m == 3 ? 9'h1 : 9'h0;
        port_full <= 0;
        repeat (2) @(posedge clk);
        if (m == 1) begin
            chk("tx", 9'(~port_tx), ind(2));
            chk("rx", 9'(~port_rx), ind(3));
        end
        toggles(m == 1 ? 0 : m == 3 ? 2 : 3, f);
        toggles(4, s);
        chk("blink", 1, m == 1 ? f > s && s > 0 : f > 0);
        port_rx <= 0;
        port_col <= 0;
        repeat (40) @(posedge clk);
        chk("idle_lit", m == 1, led_out_q[3]);
    endtask
    task automatic regs();
        logic [31:0] q;
        bus(0, `PLC_ADDR_CTRL, 0, 4'hf, q);
        chk("ctrl_reset", 1, q);
        bus(0, 4'h2, 0, 4'hf, q);
        chk("unmapped", 0, q);
        bus(1, `PLC_ADDR_CTRL, 0, 4'hf, q);
        bus(1, `PLC_ADDR_CTRL, 3, 4'he, q);
        repeat (3) @(posedge clk);
        chk("disabled", '1, led_out_q);
        bus(1, `PLC_ADDR_CTRL, 3, 4'hf, q);
        repeat (3) @(posedge clk);
        chk("lamp_test", 0, led_out_q);
        bus(1, `PLC_ADDR_CTRL, 1, 4'hf, q);
        bus(0, `PLC_ADDR_STATUS, 0, 4'hf, q);
        chk("status", {8'h05, 7'h0, port_link}, q);
    endtask
    initial begin
        logic [35:0] s;
        logic [3:0]  ms [6];
        ms = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'hc};
        for (int i = 0; i < 6; i++) begin
            s = i % 2 ? 36'h9_c5a3_6e1d : 36'h6_3a5c_91e2;
            boot(s, ms[i]);
            cfg_check(s, ms[i]);
            if (i < 4) begin
                lamps(i);
                traffic(i);
            end else begin
                repeat (4) @(posedge clk);
                chk("test_dark", '1, led_out_q);
            end
            if (i == 0)
                regs();
        end
        conclude();
    end
endmodule
bind plc_top plc_top_monitor mon (.*);
